/* hdl/tta_delay_timer.sv */
// tta_delay_timer: cycle counter standing in for an RC delay
`timescale 1ns/1ps
module tta_delay_timer #(
	parameter int W = 24,
	parameter int LEN = 400
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic run,
	output logic done
);
	// refuse lengths the counter cannot hold
	if (LEN < 1 || LEN >= (2 ** W)) begin : gBadLen
		$error("tta_delay_timer: LEN out of range");
	end

	localparam logic [W-1:0] LAST = W'(LEN - 1);
	logic [W-1:0] cnt_reg;

	// ****************************************
	// counts while run is high, restarts when run drops
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (srst || !run) begin
			cnt_reg <= '0;
			done <= 1'b0;
		end else if (cnt_reg == LAST) begin
			done <= 1'b1; // holds until run drops
		end else begin
			cnt_reg <= cnt_reg + W'(1);
		end
	end
endmodule

/* hdl/tta_pkg.sv */
// tta_pkg: shared constants and carrier types of the tape transport control block
package tta_pkg;

	// ****************************************
	// clock and delay timing
	// ****************************************
	localparam int CLK_PERIOD_PS = 5000; // ref_clk period, 200 MHz
	localparam int SAMPLE_DLY_NS = 2000; // tape_a edge to write sampling pulse
	localparam int SAMPLE_DLY_CYC = (SAMPLE_DLY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int REWIND_DLY_US = 1000; // rewind latch to high-speed request
	localparam int REWIND_DLY_CYC = (REWIND_DLY_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int FAULT_DLY_US = 2000; // tape out of path to load fault
	localparam int FAULT_DLY_CYC = (FAULT_DLY_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int TIMER_W = 24; // width of each delay counter

	// ****************************************
	// register map
	// ****************************************
	localparam logic [3:0] CTRL_OFS = 4'h0; // control word
	localparam logic [3:0] STAT_OFS = 4'h4; // status word, read only
	localparam int CTRL_EOT_JUMPER_BIT = 0; // end-passed latch drives end status
	localparam int CTRL_SOFT_CLEAR_BIT = 1; // write 1: master clear pulse
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam int STAT_WRITE_EN_BIT = 0;
	localparam int STAT_OVERWRITE_BIT = 1;
	localparam int STAT_UNLOAD_BIT = 2;
	localparam int STAT_REWIND_BIT = 3;
	localparam int STAT_MARKER_PASSED_BIT = 4;
	localparam int STAT_CREEP_BIT = 5;
	localparam int STAT_END_PASSED_BIT = 6;
	localparam int STAT_TAPE_IN_PATH_BIT = 7;
	localparam int STAT_HIGH_SPEED_BIT = 8;

	// ****************************************
	// carrier types
	// ****************************************
	// pin inputs, all asynchronous to ref_clk
	typedef struct packed {
		logic syncForwardCmd; // controller: synchronous forward
		logic syncReverseCmd; // controller: synchronous reverse
		logic writeCmd; // controller: write
		logic overwriteCmd; // controller: overwrite
		logic rewindCmd; // controller: rewind
		logic checkCharStrobeN; // data electronics: check character strobe
		logic rewindSwitch; // panel rewind switch, high while pressed
		logic endMarkerSeen; // end marker detector
		logic beginMarkerSeen; // load-point marker detector
		logic rewindRampActive; // ramp generator: high-speed ramp running
		logic interlockMade; // vacuum interlock closed
		logic onlineFlag; // unit online
		logic unitSelected; // unit addressed
		logic loadingFlag; // load sequence running
	} tta_pin_s;

	// outputs, all registered
	typedef struct packed {
		logic tapeA; // tape_a to data electronics
		logic writeEnableN; // write enable to data electronics
		logic rewindLamp;
		logic rewindingStatus;
		logic highSpeedRewindReq;
		logic reelHighVoltage; // reel servo supply on higher voltage
		logic creepForward;
		logic capstanReverse;
		logic vacuumMotorOn;
		logic reelRelayOn;
		logic reelMotorsOn; // vacuum unload drive of both reels
		logic endOfTapeStatus;
		logic loadPointStatus;
	} tta_out_s;

endpackage

/* hdl/tta_sync2.sv */
// tta_sync2: two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module tta_sync2 #(
	parameter int W = 1
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [W-1:0] asyncIn,
	output logic [W-1:0] syncOut
);
	// first stage, read by the second stage only
	logic [W-1:0] meta_reg;

	// ****************************************
	// two flops, cleared on reset
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			meta_reg <= '0;
			syncOut <= '0;
		end else begin
			meta_reg <= asyncIn;
			syncOut <= meta_reg;
		end
	end
endmodule

/* hdl/tta_transport_ctrl.sv */
// tta_transport_ctrl: write arming, rewind/unload sequencing and marker status
// ****************************************
// ****************************************
`timescale 1ns/1ps
module tta_transport_ctrl #(
	parameter int SAMPLE_CYC = tta_pkg::SAMPLE_DLY_CYC,
	parameter int REWIND_CYC = tta_pkg::REWIND_DLY_CYC,
	parameter int FAULT_CYC = tta_pkg::FAULT_DLY_CYC
) (
	input wire logic ref_clk,
	input wire logic srst,
	// classic wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// pins
	input wire tta_pkg::tta_pin_s pinIn,
	output tta_pkg::tta_out_s pinOut
);

	// ****************************************
	// elaboration checks
	// ****************************************
	if (SAMPLE_CYC < 1 || REWIND_CYC < 1 || FAULT_CYC < 1) begin : gBadCyc
		$error("tta_transport_ctrl: delay counts must be at least one");
	end

	// ****************************************
	// input synchronisers
	// ****************************************
	// every pin crosses two flops before any logic looks at it
	tta_pkg::tta_pin_s pin; // synchronised pins
	tta_sync2 #(
		.W($bits(tta_pkg::tta_pin_s))
	) uSync (
		.ref_clk(ref_clk),
		.srst(srst),
		.asyncIn(pinIn),
		.syncOut(pin)
	);

	// previous values of the synchronised pins for edge detection
	tta_pkg::tta_pin_s pinDly_reg;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pinDly_reg <= '0;
		end else begin
			pinDly_reg <= pin;
		end
	end

	// edges of interest
	wire switchReleased = pinDly_reg.rewindSwitch & ~pin.rewindSwitch;
	wire rewindCmdRise = pin.rewindCmd & ~pinDly_reg.rewindCmd;
	wire beginMarkerFall = pinDly_reg.beginMarkerSeen & ~pin.beginMarkerSeen;
	wire beginMarkerRise = pin.beginMarkerSeen & ~pinDly_reg.beginMarkerSeen;
	wire endMarkerRise = pin.endMarkerSeen & ~pinDly_reg.endMarkerSeen;
	wire endMarkerFall = pinDly_reg.endMarkerSeen & ~pin.endMarkerSeen;
	wire rampFall = pinDly_reg.rewindRampActive & ~pin.rewindRampActive;

	// ****************************************
	// state registers
	// ****************************************
	logic writeFf_reg; // write sampled
	logic noOverwriteFf_reg; // overwrite absent at sample
	logic overwriteFf_reg; // overwrite sampled
	logic sampleDoneDly_reg; // delayed sampling timer output
	logic unloadLatch_reg;
	logic rewindLatch_reg;
	logic markerPassedLatch_reg;
	logic creepForwardLatch_reg;
	logic creepEnded_reg; // one cycle between creep clear and rewind clear
	logic endPassed_reg;
	logic faultDoneDly_reg;
	logic [31:0] ctrl_reg;

	// ****************************************
	// marker decode
	// ****************************************
	// detectors rest low; both high means the reflector post is seen
	wire tapeInPath = ~(pin.endMarkerSeen & pin.beginMarkerSeen);
	wire endInternal = pin.endMarkerSeen | ~tapeInPath;
	wire atLoadPoint = pin.beginMarkerSeen & tapeInPath;

	// ****************************************
	// delay timers
	// ****************************************
	wire sampleDone;
	wire rewindDelayDone;
	wire loadFault;

	// tape_a edge delay: runs while forward tape_a is commanded
	tta_delay_timer #(
		.W(tta_pkg::TIMER_W),
		.LEN(SAMPLE_CYC)
	) uSampleDly (
		.ref_clk(ref_clk),
		.srst(srst),
		.run(pin.syncForwardCmd),
		.done(sampleDone)
	);

	// rewind delay: runs while the rewind latch is set
	tta_delay_timer #(
		.W(tta_pkg::TIMER_W),
		.LEN(REWIND_CYC)
	) uRewindDly (
		.ref_clk(ref_clk),
		.srst(srst),
		.run(rewindLatch_reg),
		.done(rewindDelayDone)
	);

	// load fault: tape pulled clear of the sensor during unload
	tta_delay_timer #(
		.W(tta_pkg::TIMER_W),
		.LEN(FAULT_CYC)
	) uFaultDly (
		.ref_clk(ref_clk),
		.srst(srst),
		.run(unloadLatch_reg & ~tapeInPath),
		.done(loadFault)
	);

	// ****************************************
	// clear network
	// ****************************************
	// a one-cycle sampling pulse, from the delayed tape_a edge only
	wire samplePulse = sampleDone & ~sampleDoneDly_reg;
	wire softClear = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0]
		& (wb_adr_i == tta_pkg::CTRL_OFS) & wb_dat_i[tta_pkg::CTRL_SOFT_CLEAR_BIT];
	wire masterClear = (loadFault & ~faultDoneDly_reg) | softClear;
	// primary clear drops the rewind latches; the marker itself only blocks a new set,
	// so a running rewind is not killed when the tape flies past the load point
	wire clearPrimary = masterClear | unloadLatch_reg | creepEnded_reg;
	wire clearSecondary = masterClear | unloadLatch_reg;

	// ****************************************
	// rewind and unload requests
	// ****************************************
	// switch at the load point unloads when online; away from it both sources rewind
	wire unloadSet = switchReleased & atLoadPoint & pin.onlineFlag;
	wire rewindSet = (rewindCmdRise | switchReleased) & ~clearPrimary & ~atLoadPoint;
	wire markerSet = rewindLatch_reg & rewindDelayDone & beginMarkerFall;
	wire creepSet = rampFall & markerPassedLatch_reg;
	wire creepClear = creepForwardLatch_reg & beginMarkerRise;

	// ****************************************
	// write arming
	// ****************************************
	// the capture flops follow the sampling pulse and drop with tape_a
	always_ff @(posedge ref_clk) begin
		if (srst || !pin.syncForwardCmd) begin
			writeFf_reg <= 1'b0;
			noOverwriteFf_reg <= 1'b0;
			overwriteFf_reg <= 1'b0;
			sampleDoneDly_reg <= 1'b0;
		end else begin
			sampleDoneDly_reg <= sampleDone;
			if (samplePulse) begin
				writeFf_reg <= pin.writeCmd;
				noOverwriteFf_reg <= ~pin.overwriteCmd;
				overwriteFf_reg <= pin.overwriteCmd;
			end else if (!pin.checkCharStrobeN) begin
				overwriteFf_reg <= 1'b0;
			end
		end
	end

	// plain write path, or overwrite path until the check strobe
	wire writeEnable = writeFf_reg & (noOverwriteFf_reg | overwriteFf_reg);

	// ****************************************
	// unload latch
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			unloadLatch_reg <= 1'b0;
			faultDoneDly_reg <= 1'b0;
		end else begin
			faultDoneDly_reg <= loadFault;
			if (unloadSet) begin
				unloadLatch_reg <= 1'b1;
			end else if (masterClear) begin
				unloadLatch_reg <= 1'b0;
			end
		end
	end

	// ****************************************
	// rewind latches
	// ****************************************
	// sets win over clears, but rewindSet is masked by clearPrimary, so a rewind request in a primary clear cycle is lost
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rewindLatch_reg <= 1'b0;
			markerPassedLatch_reg <= 1'b0;
			creepForwardLatch_reg <= 1'b0;
			creepEnded_reg <= 1'b0;
		end else begin
			creepEnded_reg <= creepClear;
			if (rewindSet) begin
				rewindLatch_reg <= 1'b1;
			end else if (clearPrimary) begin
				rewindLatch_reg <= 1'b0;
			end
			if (markerSet) begin
				markerPassedLatch_reg <= 1'b1;
			end else if (clearPrimary) begin
				markerPassedLatch_reg <= 1'b0;
			end
			if (creepSet) begin
				creepForwardLatch_reg <= 1'b1;
			end else if (creepClear || clearSecondary) begin
				creepForwardLatch_reg <= 1'b0;
			end
		end
	end

	// ****************************************
	// end-passed latch
	// ****************************************
	// clears when the marker goes by in reverse, on rewind start,
	// or when the interlock opens
	wire endPassedSet = endMarkerRise & pin.syncForwardCmd;
	wire endPassedClr = (endMarkerFall & pin.syncReverseCmd) | rewindSet
		| ~pin.interlockMade;
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			endPassed_reg <= 1'b0;
		end else if (endPassedSet) begin
			endPassed_reg <= 1'b1;
		end else if (endPassedClr) begin
			endPassed_reg <= 1'b0;
		end
	end

	// ****************************************
	// output decode
	// ****************************************
	// the high-speed request falls as soon as the marker has gone by
	wire highSpeed = rewindLatch_reg & rewindDelayDone & ~markerPassedLatch_reg;
	wire eotJumper = ctrl_reg[tta_pkg::CTRL_EOT_JUMPER_BIT];
	wire endStatus = ~rewindLatch_reg
		& (endInternal | (eotJumper & endPassed_reg));
	// the load-point line is hidden while loading, rewinding or without tape
	wire loadPointStatus = pin.beginMarkerSeen & tapeInPath & ~rewindLatch_reg
		& ~creepForwardLatch_reg & ~pin.loadingFlag;

	tta_pkg::tta_out_s outNext;
	always_comb begin
		outNext = '0;
		outNext.tapeA = pin.syncForwardCmd;
		outNext.writeEnableN = ~writeEnable;
		outNext.rewindLamp = rewindLatch_reg;
		outNext.rewindingStatus = rewindLatch_reg & pin.unitSelected;
		outNext.highSpeedRewindReq = highSpeed;
		outNext.reelHighVoltage = highSpeed;
		outNext.creepForward = creepForwardLatch_reg;
		outNext.capstanReverse = unloadLatch_reg;
		outNext.vacuumMotorOn = pin.interlockMade & ~unloadLatch_reg;
		outNext.reelRelayOn = pin.interlockMade | unloadLatch_reg;
		outNext.reelMotorsOn = unloadLatch_reg & ~pin.interlockMade;
		outNext.endOfTapeStatus = endStatus;
		outNext.loadPointStatus = loadPointStatus;
	end

	// every output leaves from a flop
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			pinOut <= '{writeEnableN: 1'b1, default: 1'b0};
		end else begin
			pinOut <= outNext;
		end
	end

	// ****************************************
	// wishbone slave
	// ****************************************
	// one wait state: ack one cycle after the strobe, dropped the next
	wire wbReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire ctrlHit = wb_adr_i == tta_pkg::CTRL_OFS;
	wire statHit = wb_adr_i == tta_pkg::STAT_OFS;

	// status word shows the block's own state
	logic [31:0] statWord;
	always_comb begin
		statWord = '0;
		statWord[tta_pkg::STAT_WRITE_EN_BIT] = writeEnable;
		statWord[tta_pkg::STAT_OVERWRITE_BIT] = overwriteFf_reg;
		statWord[tta_pkg::STAT_UNLOAD_BIT] = unloadLatch_reg;
		statWord[tta_pkg::STAT_REWIND_BIT] = rewindLatch_reg;
		statWord[tta_pkg::STAT_MARKER_PASSED_BIT] = markerPassedLatch_reg;
		statWord[tta_pkg::STAT_CREEP_BIT] = creepForwardLatch_reg;
		statWord[tta_pkg::STAT_END_PASSED_BIT] = endPassed_reg;
		statWord[tta_pkg::STAT_TAPE_IN_PATH_BIT] = tapeInPath;
		statWord[tta_pkg::STAT_HIGH_SPEED_BIT] = highSpeed;
	end

	// read mux; unmapped offsets read zero and are still acknowledged
	wire [31:0] rdData = ctrlHit ? {30'h0, ctrl_reg[1:0]} : (statHit ? statWord : 32'h0);

	// control register write through byte lane 0 only; soft clear bit self-clears
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ctrl_reg <= tta_pkg::CTRL_RESET;
		end else if (wbReq && wb_we_i && ctrlHit && wb_sel_i[0]) begin
			ctrl_reg[7:0] <= {wb_dat_i[7:2], 1'b0, wb_dat_i[0]};
		end
	end

	// ack and read data registers
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= wbReq;
			wb_dat_o <= (wbReq && !wb_we_i) ? rdData : 32'h0;
		end
	end
endmodule

/* testbench/tb_top.sv */
// tb_top: self-checking bench for the transport control block
`timescale 1ns/1ps
module tb_top;
	logic ref_clk, srst, wbCyc, wbStb, wbWe, wbAck, tapeOut, atEnd;
	logic mBegin, mEnd, mRamp;
	logic [3:0] wbAdr, wbSel;
	logic [31:0] wbDat, wbDatO, rd, rnd;
	tta_pkg::tta_pin_s drv, pinIn;
	tta_pkg::tta_out_s pinOut;
	int failures, comparisons, seed, mCtrl; // mCtrl: model of the control word
	// ****************************************
	// clock, design, partner
	// ****************************************
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// model owns the marker and ramp lines
	always_comb begin
		pinIn = drv;
		pinIn.beginMarkerSeen = mBegin;
		pinIn.endMarkerSeen = mEnd;
		pinIn.rewindRampActive = mRamp;
	end
	tta_transport_ctrl #(.SAMPLE_CYC(8), .REWIND_CYC(20), .FAULT_CYC(20)) dut (
		.ref_clk(ref_clk), .srst(srst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
		.wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
		.wb_dat_o(wbDatO), .wb_ack_o(wbAck), .pinIn(pinIn), .pinOut(pinOut));
	tta_tape_model model (.ref_clk(ref_clk), .srst(srst), .drive(pinOut),
		.tapeOut(tapeOut), .atEnd(atEnd), .beginMarker(mBegin),
		.endMarker(mEnd), .rampActive(mRamp));
	// ****************************************
	// tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// one classic cycle; waits for ack, then one idle cycle
	task automatic bus(input logic we, input logic [3:0] adr, input logic [31:0] dat);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= adr;
		wbDat <= dat;
		do begin
			@(posedge ref_clk);
		end while (wbAck !== 1'b1);
		rd = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd_chk(input logic [3:0] adr, input logic [31:0] exp);
		bus(1'b0, adr, 32'h0);
		check(rd, exp);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	// bounded wait for one output bit, then compare it
	task automatic wait_out(input int b, input logic v);
		int n;
		n = 0;
		while (pinOut[b] !== v && n < 200) begin
			@(posedge ref_clk);
			n++;
		end
		check(32'(pinOut[b]), 32'(v));
	endtask
	task automatic finish_test();
		if (failures == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// watchdog: the sequence needs well under 2000 cycles
	initial begin
		repeat (5000) @(posedge ref_clk);
		failures++;
		finish_test();
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		seed = 6488;
		failures = 0;
		comparisons = 0;
		{wbCyc, wbStb, wbWe, wbAdr, wbDat, tapeOut, atEnd} = '0;
		wbSel = 4'hf;
		drv = '0;
		drv.checkCharStrobeN = 1'b1;
		drv.interlockMade = 1'b1;
		drv.onlineFlag = 1'b1;
		drv.unitSelected = 1'b1;
		srst = 1'b1;
		cyc(16);
		check(32'(pinOut), 32'h0800);
		srst <= 1'b0;
		cyc(6);
		check(32'(pinOut), 32'h0818);
		// registers: random control word, read-only status, unmapped
		rd_chk(tta_pkg::CTRL_OFS, 32'h0);
		rnd = $random(seed);
		bus(1'b1, tta_pkg::CTRL_OFS, rnd);
		mCtrl = rnd[0];
		rd_chk(tta_pkg::CTRL_OFS, mCtrl);
		bus(1'b1, tta_pkg::STAT_OFS, $random(seed));
		rd_chk(tta_pkg::STAT_OFS, 32'h80);
		rnd = $random(seed);
		bus(1'b1, 4'h8 | rnd[2:0], rnd);
		rd_chk(4'h8 | rnd[6:4], 32'h0);
		bus(1'b1, tta_pkg::CTRL_OFS, 32'h1);
		mCtrl = 1;
		rd_chk(tta_pkg::CTRL_OFS, mCtrl);
		// plain write: enable arrives only after the delayed sample
		drv.syncForwardCmd <= 1'b1;
		drv.writeCmd <= 1'b1;
		cyc(6);
		check(32'(pinOut.writeEnableN), 32'h1);
		wait_out(11, 1'b0);
		check(32'(pinOut.tapeA), 32'h1);
		rd_chk(tta_pkg::STAT_OFS, 32'h81);
		drv.syncForwardCmd <= 1'b0;
		drv.writeCmd <= 1'b0;
		wait_out(11, 1'b1);
		// overwrite, ended by the check strobe
		drv.syncForwardCmd <= 1'b1;
		drv.writeCmd <= 1'b1;
		drv.overwriteCmd <= 1'b1;
		wait_out(11, 1'b0);
		rd_chk(tta_pkg::STAT_OFS, 32'h83);
		drv.checkCharStrobeN <= 1'b0;
		wait_out(11, 1'b1);
		{drv.syncForwardCmd, drv.writeCmd, drv.overwriteCmd} <= 3'h0;
		drv.checkCharStrobeN <= 1'b1;
		cyc(6);
		// end marker passed forward, then interlock break
		drv.syncForwardCmd <= 1'b1;
		atEnd <= 1'b1;
		cyc(8);
		atEnd <= 1'b0;
		cyc(6);
		drv.syncForwardCmd <= 1'b0;
		cyc(6);
		check(32'(pinOut.endOfTapeStatus), 32'h1);
		rd_chk(tta_pkg::STAT_OFS, 32'hc0);
		drv.interlockMade <= 1'b0;
		cyc(6);
		check(32'(pinOut.endOfTapeStatus), 32'h0);
		drv.interlockMade <= 1'b1;
		cyc(6);
		// rewind away from the marker, creep back and park
		drv.rewindCmd <= 1'b1;
		wait_out(10, 1'b1);
		drv.rewindCmd <= 1'b0;
		cyc(2);
		check(32'(pinOut.rewindingStatus), 32'h1);
		drv.unitSelected <= 1'b0;
		cyc(4);
		check(32'(pinOut.rewindingStatus), 32'h0);
		drv.unitSelected <= 1'b1;
		wait_out(8, 1'b1);
		check(32'(pinOut.reelHighVoltage), 32'h1);
		rd_chk(tta_pkg::STAT_OFS, 32'h188);
		wait_out(6, 1'b1);
		check(32'(pinOut.highSpeedRewindReq), 32'h0);
		wait_out(10, 1'b0);
		check(32'(pinOut.creepForward), 32'h0);
		cyc(4);
		check(32'(pinOut.loadPointStatus), 32'h1);
		drv.loadingFlag <= 1'b1;
		cyc(4);
		check(32'(pinOut.loadPointStatus), 32'h0);
		drv.loadingFlag <= 1'b0;
		cyc(4);
		rd_chk(tta_pkg::STAT_OFS, 32'h80);
		// panel switch at the load point unloads instead
		drv.rewindSwitch <= 1'b1;
		cyc(5);
		drv.rewindSwitch <= 1'b0;
		wait_out(5, 1'b1);
		cyc(2);
		check(32'(pinOut.rewindLamp), 32'h0);
		check(32'(pinOut.vacuumMotorOn), 32'h0);
		check(32'(pinOut.reelRelayOn), 32'h1);
		rd_chk(tta_pkg::STAT_OFS, 32'h84);
		drv.interlockMade <= 1'b0;
		wait_out(2, 1'b1);
		tapeOut <= 1'b1;
		cyc(6);
		check(32'(pinOut.endOfTapeStatus), 32'h1);
		check(32'(pinOut.loadPointStatus), 32'h0);
		wait_out(2, 1'b0);
		check(32'(pinOut.capstanReverse), 32'h0);
		finish_test();
	end
endmodule

/* testbench/tta_tape_model.sv */
// tta_tape_model: behavioural tape mechanics, markers and rewind ramp
`timescale 1ns/1ps
module tta_tape_model (
	input wire logic ref_clk,
	input wire logic srst,
	input wire tta_pkg::tta_out_s drive,
	input wire logic tapeOut,
	input wire logic atEnd,
	output logic beginMarker,
	output logic endMarker,
	output logic rampActive
);
	int hsCnt; // cycles at high speed
	int rampCnt; // ramp-down left
	int creepCnt; // cycles creeping forward
	logic parked; // tape resting on load point
	// tape passes the marker 30 cycles into high speed, ramp lags the request
	always @(posedge ref_clk) begin
		if (srst) begin
			hsCnt <= 0;
			rampCnt <= 0;
			creepCnt <= 0;
			parked <= 1'b0;
		end else begin
			hsCnt <= drive.highSpeedRewindReq ? hsCnt + 1 : 0;
			rampCnt <= drive.highSpeedRewindReq ? 12 : (rampCnt > 0 ? rampCnt - 1 : 0);
			creepCnt <= drive.creepForward ? creepCnt + 1 : 0;
			if (creepCnt == 6) begin
				parked <= 1'b1;
			end else if (drive.highSpeedRewindReq) begin
				parked <= 1'b0;
			end
		end
	end
	// detectors rest low; both high once tape leaves the path
	assign beginMarker = tapeOut | parked | (hsCnt >= 30 && hsCnt < 34);
	assign endMarker = tapeOut | atEnd;
	assign rampActive = rampCnt > 0;
endmodule

/* testbench/tta_transport_checker.sv */
// tta_transport_checker: port assertions for the transport control block
`timescale 1ns/1ps
module tta_transport_checker #(
	parameter int SAMPLE_CYC = 8,
	parameter int REWIND_CYC = 20
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire tta_pkg::tta_pin_s pinIn,
	input wire tta_pkg::tta_out_s pinOut
);
	// ****************************************
	// bus and sequencing properties
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	// a request the slave has not yet answered
	sequence busReq;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	// answer is exactly one cycle wide
	sequence ackOnce;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	bus_answer_a: assert property (busReq |=> ackOnce)
		else $error("bus request not answered by one ack");
	read_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data not zero outside ack");
	write_sample_a: assert property ($fell(pinOut.writeEnableN) |-> $past(pinOut.tapeA, SAMPLE_CYC/2))
		else $error("write enable without prior tape_a");
	status_lamp_a: assert property (pinOut.rewindingStatus |-> pinOut.rewindLamp)
		else $error("rewinding status without lamp");
	hs_delay_a: assert property ($rose(pinOut.highSpeedRewindReq) |-> $past(pinOut.rewindLamp, REWIND_CYC-2))
		else $error("high speed request too early");
	hs_voltage_a: assert property (pinOut.highSpeedRewindReq && $past(pinOut.highSpeedRewindReq) |-> pinOut.reelHighVoltage)
		else $error("reel supply not raised");
	creep_excl_a: assert property (pinOut.creepForward |-> !pinOut.highSpeedRewindReq && pinOut.rewindLamp)
		else $error("creep outside rewind tail");
	park_end_a: assert property ($fell(pinOut.creepForward) |-> ##[0:2] !pinOut.rewindLamp)
		else $error("rewind latch not cleared after creep");
	vacuum_relay_a: assert property (pinOut.vacuumMotorOn |-> pinOut.reelRelayOn)
		else $error("vacuum on without reel relay");
	eot_rewind_a: assert property (pinOut.rewindLamp && $past(pinOut.rewindLamp) |-> !pinOut.endOfTapeStatus)
		else $error("end status during rewind");
	lp_rewind_a: assert property (pinOut.rewindLamp && $past(pinOut.rewindLamp) |-> !pinOut.loadPointStatus)
		else $error("load point status during rewind");
	absent_eot_a: assert property ((pinIn.endMarkerSeen && pinIn.beginMarkerSeen && !pinOut.rewindLamp) [*5] |-> pinOut.endOfTapeStatus)
		else $error("absent tape not flagged");
endmodule

bind tta_transport_ctrl tta_transport_checker #(
	.SAMPLE_CYC(SAMPLE_CYC),
	.REWIND_CYC(REWIND_CYC)
) chk (
	.ref_clk(ref_clk),
	.srst(srst),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.pinIn(pinIn),
	.pinOut(pinOut)
);
